//--- inc/csl_pkg.sv
// code security lock package: sfr offsets, field positions, codes and timing
// assumes an 8-bit special-function register port from the processor core
package csl_pkg;

  // ------------------------------------------------------------------
  // sfr offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_ERASE_TRIGGER = 8'h94;
  localparam logic [7:0] ADDR_FLASH_CTL = 8'hb2;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'hb7;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_EARLY_BOOT = 7;
  localparam int BIT_CODE_LOCK = 6;
  localparam int BIT_BULK_ARM = 1;
  localparam int BIT_CODE_WE = 0;
  localparam int BIT_EMU_CLK_OFF = 5;
  localparam int PAGE_SEL_LSB = 1;

  // ------------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CODE_PAGE_ERASE = 8'h55;
  localparam logic [7:0] CODE_MASS_ERASE = 8'haa;
  localparam logic [7:0] RST_CFG1 = 8'h00;
  localparam logic [6:0] RST_PAGE_SEL = 7'h00;
  localparam logic [6:0] PAGE_ZERO = 7'h00;

  // ------------------------------------------------------------------
  // timing: early-boot window in processor cycles
  // ------------------------------------------------------------------
  localparam int EARLY_BOOT_CYCLES = 32;
  localparam logic [5:0] EARLY_BOOT_LAST = 6'(EARLY_BOOT_CYCLES - 1);

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csl_sfr_req_t;

  typedef struct packed {
    logic req;
    logic is_read;
    logic is_write;
    logic is_page_erase;
    logic is_mass_erase;
    logic [6:0] page;
  } csl_emu_req_t;

  typedef struct packed {
    logic req;
    logic [6:0] page;
  } csl_flash_wr_t;

endpackage : csl_pkg

//--- hw/csl_boot_timer.sv
// early-boot cycle counter for the code security lock
// assumes reset release marks the first cycle of boot code execution
`timescale 1ns/10ps
`default_nettype none
module csl_boot_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  output logic early_boot_o
);

  logic [5:0] cnt_q;
  logic active_q;

  // ------------------------------------------------------------------
  // counts the first cycles after reset, then stays idle until next reset
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 6'h00;
      active_q <= 1'b1;
    end else if (active_q) begin
      if (cnt_q == csl_pkg::EARLY_BOOT_LAST) begin
        active_q <= 1'b0;
      end
      cnt_q <= cnt_q + 6'h01;
    end
  end

  assign early_boot_o = active_q;

endmodule // csl_boot_timer
`default_nettype wire

//--- hw/csl_top.sv
// code security lock: lock bit, early-boot window, emulator gating, flash guard
// assumes a single-cycle sfr port from the core and one-cycle request pulses
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R1 - lock limits emulator to global erase only
// R2 - lock settable by early-boot code
// R3 - lock stays until mass erase then reset
// R4 - mass erase also clears engine program ram
// R5 - emulator blocked for first 32 cycles
// R6 - early-boot flag readable at 0xb2 bit 7
// R7 - emulator allowed after early boot, lock permitting
// R8 - lock bit cleared on processor reset
// R9 - lock write-one-to-set, zero ignored
// R10 - lock blocks emulator code reads
// R11 - lock refuses page zero page erase
// R12 - lock suppresses page zero writes
// R13 - programmer should reset chip after erase
// R14 - emulator clock off bit stops emulator
// R15 - unused bits read as zero
// R16 - software keeps reserved bits unchanged
// R17 - configuration bits clear at power-up
// R18 - 0x55 starts page erase of selected page
// R19 - 0xaa mass erase needs arm and port
// R20 - write enable self-clears, blocked with interrupts
module csl_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic CFG1_WR_I,
  input wire logic [7:0] CFG1_WDATA_I,
  input wire logic INT_ENABLED_I,
  input wire logic EMU_ENABLE_I,
  input wire logic EMU_REQ_I,
  input wire logic EMU_READ_I,
  input wire logic EMU_WRITE_I,
  input wire logic EMU_PAGE_ERASE_I,
  input wire logic EMU_MASS_ERASE_I,
  input wire logic [6:0] EMU_PAGE_I,
  input wire logic CPU_FLASH_WR_I,
  input wire logic [6:0] CPU_FLASH_PAGE_I,
  input wire logic FLASH_BYTE_DONE_I,
  output logic [7:0] SFR_RDATA_O,
  output logic [7:0] CFG1_RDATA_O,
  output logic CODE_LOCK_O,
  output logic EARLY_BOOT_O,
  output logic CODE_WRITE_ENABLE_O,
  output logic EMU_CLK_EN_O,
  output logic EMU_GRANT_O,
  output logic EMU_REJECT_O,
  output logic EMU_HALT_CPU_O,
  output logic FLASH_WR_O,
  output logic [6:0] FLASH_WR_PAGE_O,
  output logic PAGE_ERASE_O,
  output logic [6:0] PAGE_ERASE_ADDR_O,
  output logic MASS_ERASE_O,
  output logic ENG_RAM_CLEAR_O
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic is_page_zero(input logic [6:0] page);
    is_page_zero = (page == csl_pkg::PAGE_ZERO);
  endfunction

  function automatic logic sfr_hit(input csl_pkg::csl_sfr_req_t r, input logic [7:0] a);
    sfr_hit = r.wr && (r.addr == a);
  endfunction

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  csl_pkg::csl_sfr_req_t sfr;
  csl_pkg::csl_emu_req_t emu;
  csl_pkg::csl_flash_wr_t cpu_wr;
  logic early_boot;
  logic code_lock_q;
  logic bulk_arm_q;
  logic code_we_q;
  logic [6:0] page_sel_q;
  logic [7:0] cfg1_q;
  logic emu_clock_off;
  logic emu_usable;
  logic mass_ok;
  logic [7:0] rdata_d;
  logic [7:0] ctl_view;
  logic wr_ctl;
  logic wr_trig;
  logic wr_page;
  logic emu_mass;
  logic cpu_mass;
  logic emu_page_erase_ok;
  logic cpu_page_erase_ok;
  logic emu_write_ok;
  logic cpu_write_ok;
  logic emu_read_ok;

  assign sfr = '{wr: SFR_WR_I, rd: SFR_RD_I, addr: SFR_ADDR_I, wdata: SFR_WDATA_I};
  assign emu = '{req: EMU_REQ_I, is_read: EMU_READ_I, is_write: EMU_WRITE_I,
                 is_page_erase: EMU_PAGE_ERASE_I, is_mass_erase: EMU_MASS_ERASE_I,
                 page: EMU_PAGE_I};
  assign cpu_wr = '{req: CPU_FLASH_WR_I, page: CPU_FLASH_PAGE_I};

  // ------------------------------------------------------------------
  // early-boot window
  // ------------------------------------------------------------------
  csl_boot_timer u_boot_timer (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .early_boot_o(early_boot)
  );

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  assign wr_ctl = sfr_hit(sfr, csl_pkg::ADDR_FLASH_CTL);
  assign wr_trig = sfr_hit(sfr, csl_pkg::ADDR_ERASE_TRIGGER);
  assign wr_page = sfr_hit(sfr, csl_pkg::ADDR_PAGE_SEL);
  assign emu_clock_off = cfg1_q[csl_pkg::BIT_EMU_CLK_OFF]; // [R14]
  // emulator is dead during early boot or with its clock stopped
  assign emu_usable = EMU_ENABLE_I && !early_boot && !emu_clock_off; // [R5] [R7] [R14]
  assign mass_ok = bulk_arm_q && emu_usable; // [R19]

  // ------------------------------------------------------------------
  // lock bit: write-one-to-set, only a reset clears it
  // ------------------------------------------------------------------
  // reset is the only clear, so a mass erase leaves it set until the next reset
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      code_lock_q <= 1'b0; // [R8] [R3]
    end else if (wr_ctl && early_boot && sfr.wdata[csl_pkg::BIT_CODE_LOCK]) begin
      code_lock_q <= 1'b1; // [R2] [R9]
    end
  end

  // ------------------------------------------------------------------
  // bulk erase arm: consumed by every mass erase trigger write
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      bulk_arm_q <= 1'b0;
    end else if (wr_ctl) begin
      bulk_arm_q <= sfr.wdata[csl_pkg::BIT_BULK_ARM];
    end else if (wr_trig && sfr.wdata == csl_pkg::CODE_MASS_ERASE) begin
      bulk_arm_q <= 1'b0; // [R19]
    end else if (emu.req && emu.is_mass_erase && emu_usable) begin
      bulk_arm_q <= 1'b0; // [R19]
    end
  end

  // ------------------------------------------------------------------
  // code write enable: self-clear wins over a same-cycle write
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      code_we_q <= 1'b0;
    end else if (FLASH_BYTE_DONE_I) begin
      code_we_q <= 1'b0; // [R20]
    end else if (wr_ctl && !INT_ENABLED_I) begin
      code_we_q <= sfr.wdata[csl_pkg::BIT_CODE_WE]; // [R20]
    end
  end

  // ------------------------------------------------------------------
  // page select and configuration
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      page_sel_q <= csl_pkg::RST_PAGE_SEL;
    end else if (wr_page) begin
      page_sel_q <= sfr.wdata[7:csl_pkg::PAGE_SEL_LSB];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg1_q <= csl_pkg::RST_CFG1; // [R17]
    end else if (CFG1_WR_I) begin
      cfg1_q <= CFG1_WDATA_I;
    end
  end

  // ------------------------------------------------------------------
  // erase and write qualification
  // ------------------------------------------------------------------
  assign cpu_mass = wr_trig && (sfr.wdata == csl_pkg::CODE_MASS_ERASE) && mass_ok; // [R19]
  assign emu_mass = emu.req && emu.is_mass_erase && mass_ok; // [R1] [R19]
  // page zero only goes away by mass erase while locked
  assign cpu_page_erase_ok = wr_trig && (sfr.wdata == csl_pkg::CODE_PAGE_ERASE)
                             && !(code_lock_q && is_page_zero(page_sel_q)); // [R18] [R11]
  // emulator page erase is refused whenever locked, which covers page zero as well
  assign emu_page_erase_ok = emu.req && emu.is_page_erase && emu_usable && !code_lock_q; // [R1] [R11]
  assign cpu_write_ok = cpu_wr.req && code_we_q
                        && !(code_lock_q && is_page_zero(cpu_wr.page)); // [R12]
  assign emu_write_ok = emu.req && emu.is_write && emu_usable && !code_lock_q; // [R1] [R12]
  assign emu_read_ok = emu.req && emu.is_read && emu_usable && !code_lock_q; // [R10]

  // ------------------------------------------------------------------
  // flash command outputs, registered
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MASS_ERASE_O <= 1'b0;
      ENG_RAM_CLEAR_O <= 1'b0;
    end else begin
      MASS_ERASE_O <= cpu_mass || emu_mass;
      ENG_RAM_CLEAR_O <= cpu_mass || emu_mass; // [R4]
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PAGE_ERASE_O <= 1'b0;
      PAGE_ERASE_ADDR_O <= csl_pkg::RST_PAGE_SEL;
    end else begin
      PAGE_ERASE_O <= cpu_page_erase_ok || emu_page_erase_ok; // [R18]
      PAGE_ERASE_ADDR_O <= page_sel_q;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FLASH_WR_O <= 1'b0;
      FLASH_WR_PAGE_O <= csl_pkg::PAGE_ZERO;
    end else begin
      FLASH_WR_O <= cpu_write_ok || emu_write_ok; // [R12]
      FLASH_WR_PAGE_O <= emu_write_ok ? emu.page : cpu_wr.page;
    end
  end

  // ------------------------------------------------------------------
  // emulator answers, registered
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      EMU_GRANT_O <= 1'b0;
      EMU_REJECT_O <= 1'b0;
    end else begin
      EMU_GRANT_O <= emu_read_ok || emu_write_ok || emu_page_erase_ok || emu_mass;
      EMU_REJECT_O <= emu.req && !(emu_read_ok || emu_write_ok
                      || emu_page_erase_ok || emu_mass); // [R1] [R5]
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      EMU_CLK_EN_O <= 1'b0;
      EMU_HALT_CPU_O <= 1'b0;
    end else begin
      EMU_CLK_EN_O <= !emu_clock_off; // [R14]
      EMU_HALT_CPU_O <= emu_usable && !code_lock_q; // [R7] [R1]
    end
  end

  // ------------------------------------------------------------------
  // status mirrors
  // ------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CODE_LOCK_O <= 1'b0;
      EARLY_BOOT_O <= 1'b1;
      CODE_WRITE_ENABLE_O <= 1'b0;
    end else begin
      CODE_LOCK_O <= code_lock_q;
      EARLY_BOOT_O <= early_boot;
      CODE_WRITE_ENABLE_O <= code_we_q;
    end
  end

  // ------------------------------------------------------------------
  // sfr read path: write-only registers and unused bits read zero
  // ------------------------------------------------------------------
  always_comb begin
    ctl_view = 8'h00; // [R15]
    ctl_view[csl_pkg::BIT_EARLY_BOOT] = early_boot; // [R6]
    ctl_view[csl_pkg::BIT_CODE_LOCK] = code_lock_q;
    ctl_view[csl_pkg::BIT_CODE_WE] = code_we_q;
    rdata_d = 8'h00;
    if (sfr.rd && sfr.addr == csl_pkg::ADDR_FLASH_CTL) begin
      rdata_d = ctl_view;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SFR_RDATA_O <= 8'h00;
      CFG1_RDATA_O <= csl_pkg::RST_CFG1;
    end else begin
      SFR_RDATA_O <= rdata_d;
      CFG1_RDATA_O <= cfg1_q; // reserved bits stored as written
    end
  end

endmodule // csl_top
`default_nettype wire

//--- verification/csl_top_props.sv
// checker for the code security lock, watching the top module ports only
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module csl_top_props (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic EMU_REQ_I,
  input wire logic EMU_READ_I,
  input wire logic CODE_LOCK_O,
  input wire logic EARLY_BOOT_O,
  input wire logic EMU_GRANT_O,
  input wire logic EMU_REJECT_O,
  input wire logic FLASH_WR_O,
  input wire logic [6:0] FLASH_WR_PAGE_O,
  input wire logic PAGE_ERASE_O,
  input wire logic [6:0] PAGE_ERASE_ADDR_O,
  input wire logic MASS_ERASE_O,
  input wire logic ENG_RAM_CLEAR_O
);
  logic lock_wr;
  logic bad_code;
  assign lock_wr = SFR_WR_I && SFR_ADDR_I == csl_pkg::ADDR_FLASH_CTL && SFR_WDATA_I[csl_pkg::BIT_CODE_LOCK];
  assign bad_code = SFR_WR_I && SFR_ADDR_I == csl_pkg::ADDR_ERASE_TRIGGER && !EMU_REQ_I
    && SFR_WDATA_I != csl_pkg::CODE_PAGE_ERASE && SFR_WDATA_I != csl_pkg::CODE_MASS_ERASE;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  a_lock_sticky: assert property (CODE_LOCK_O |=> CODE_LOCK_O)
    else $error("lock dropped without reset");
  a_lock_cause: assert property ($rose(CODE_LOCK_O) |-> $past(lock_wr, 2))
    else $error("lock rose without a lock write");
  a_boot_blocks: assert property (EMU_GRANT_O |-> !EARLY_BOOT_O)
    else $error("emulator granted in early boot");
  a_emu_answer: assert property (EMU_REQ_I |=> EMU_GRANT_O != EMU_REJECT_O)
    else $error("emulator request not answered once");
  a_locked_read: assert property (EMU_REQ_I && EMU_READ_I && CODE_LOCK_O |=> EMU_REJECT_O)
    else $error("locked code read not rejected");
  a_page0_write: assert property (FLASH_WR_O && CODE_LOCK_O |-> FLASH_WR_PAGE_O != csl_pkg::PAGE_ZERO)
    else $error("page zero written while locked");
  a_page0_erase: assert property (PAGE_ERASE_O && CODE_LOCK_O |-> PAGE_ERASE_ADDR_O != csl_pkg::PAGE_ZERO)
    else $error("page zero erased while locked");
  a_mass_ram: assert property (MASS_ERASE_O == ENG_RAM_CLEAR_O)
    else $error("mass erase and program ram clear differ");
  a_bad_code: assert property (bad_code |=> !PAGE_ERASE_O && !MASS_ERASE_O)
    else $error("unknown trigger code started an erase");
  c_lock: cover property ($rose(CODE_LOCK_O));
  c_mass: cover property (MASS_ERASE_O);
  c_page: cover property (PAGE_ERASE_O && CODE_LOCK_O);
  c_grant: cover property (EMU_GRANT_O && CODE_LOCK_O);
endmodule // csl_top_props
bind csl_top csl_top_props u_props (.*);
`default_nettype wire

//--- verification/csl_emu_model.sv
// emulator port model: one request at a time, held until the answer edge
// assumes the caller enters each operation just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module csl_emu_model (
  input wire logic clk_i,
  input wire logic grant_i,
  input wire logic reject_i,
  output logic en_o,
  output logic req_o,
  output logic rd_o,
  output logic wr_o,
  output logic pe_o,
  output logic me_o,
  output logic [6:0] page_o
);
  // port starts enabled so that bulk erase remains reachable
  initial begin
    en_o = 1'b1;
    {req_o, rd_o, wr_o, pe_o, me_o} = '0;
    page_o = 7'h2a;
  end
  // port enable level, changed by the caller just after a rising edge
  task automatic enable(input logic on);
    en_o = on;
  endtask
  // kinds: 0 read, 1 write, 2 page erase, 3 mass erase
  task automatic op(input int kind, input logic [6:0] page, output logic g, output logic r);
    req_o = 1'b1;
    {rd_o, wr_o, pe_o, me_o} = {kind == 0, kind == 1, kind == 2, kind == 3};
    page_o = page;
    @(posedge clk_i);
    #2;
    g = grant_i;
    r = reject_i;
    {req_o, rd_o, wr_o, pe_o, me_o} = '0;
    // released field must not look valid
    page_o = ~page;
    @(posedge clk_i);
    #2;
  endtask
endmodule // csl_emu_model
`default_nettype wire

//--- verification/code_security_lock_bench.sv
// self-checking bench for the code security lock
// assumes csl_top, its checker and the emulator model are compiled before it
`timescale 1ns/10ps
`default_nettype none
module code_security_lock_bench;
  logic SYS_CLK_I = 1'b0;
  logic RST_B_I, SFR_WR_I, SFR_RD_I, CFG1_WR_I, INT_ENABLED_I, CPU_FLASH_WR_I, FLASH_BYTE_DONE_I;
  logic [7:0] SFR_ADDR_I, SFR_WDATA_I, CFG1_WDATA_I, SFR_RDATA_O, CFG1_RDATA_O, rd, d;
  logic [6:0] EMU_PAGE_I, CPU_FLASH_PAGE_I, FLASH_WR_PAGE_O, PAGE_ERASE_ADDR_O, pa, fp, p;
  logic EMU_ENABLE_I, EMU_REQ_I, EMU_READ_I, EMU_WRITE_I, EMU_PAGE_ERASE_I, EMU_MASS_ERASE_I;
  logic CODE_LOCK_O, EARLY_BOOT_O, CODE_WRITE_ENABLE_O, EMU_CLK_EN_O, EMU_GRANT_O, EMU_REJECT_O;
  logic EMU_HALT_CPU_O, FLASH_WR_O, PAGE_ERASE_O, MASS_ERASE_O, ENG_RAM_CLEAR_O, g, r, pe, me, pc, fw;
  logic [31:0] seed = 32'hcde3;
  int fails = 0, n_tests = 0, m_lock = 0, cyc = 0;
  always #12.5 SYS_CLK_I = ~SYS_CLK_I;
  always @(posedge SYS_CLK_I) cyc <= RST_B_I ? cyc + 1 : 0;
  csl_top dut (.*);
  csl_emu_model emu (.clk_i(SYS_CLK_I), .grant_i(EMU_GRANT_O), .reject_i(EMU_REJECT_O), .en_o(EMU_ENABLE_I),
    .req_o(EMU_REQ_I), .rd_o(EMU_READ_I), .wr_o(EMU_WRITE_I), .pe_o(EMU_PAGE_ERASE_I),
    .me_o(EMU_MASS_ERASE_I), .page_o(EMU_PAGE_I));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s at %0t got %h exp %h", what, $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic sfr(input logic rd_n, input logic [7:0] a, input logic [7:0] v);
    {SFR_WR_I, SFR_RD_I, SFR_ADDR_I, SFR_WDATA_I} = {!rd_n, rd_n, a, v};
    @(posedge SYS_CLK_I);
    #2;
    {pe, pa, me, pc, rd} = {PAGE_ERASE_O, PAGE_ERASE_ADDR_O, MASS_ERASE_O, ENG_RAM_CLEAR_O, SFR_RDATA_O};
    {SFR_WR_I, SFR_RD_I, SFR_ADDR_I, SFR_WDATA_I} = {2'b00, ~a, ~v};
    @(posedge SYS_CLK_I);
    #2;
  endtask
  task automatic cpu_wr(input logic [6:0] pg);
    {CPU_FLASH_WR_I, CPU_FLASH_PAGE_I} = {1'b1, pg};
    @(posedge SYS_CLK_I);
    #2;
    {fw, fp} = {FLASH_WR_O, FLASH_WR_PAGE_O};
    {CPU_FLASH_WR_I, CPU_FLASH_PAGE_I, FLASH_BYTE_DONE_I} = {1'b0, ~pg, 1'b1};
    @(posedge SYS_CLK_I);
    #2;
    FLASH_BYTE_DONE_I = 1'b0;
    @(posedge SYS_CLK_I);
    #2;
  endtask
  task automatic do_reset();
    RST_B_I = 1'b0;
    repeat (5) @(posedge SYS_CLK_I);
    #2;
    RST_B_I = 1'b1;
    m_lock = 0;
  endtask
  task automatic boot_end();
    for (int i = 0; i < 60 && EARLY_BOOT_O; i++) begin
      @(posedge SYS_CLK_I);
      #2;
    end
    if (EARLY_BOOT_O !== 1'b0) begin
      fails++;
      conclude();
    end
    chk(cyc >= 32 && cyc <= 34, 1, "boot length");
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {RST_B_I, SFR_WR_I, SFR_RD_I, CFG1_WR_I, INT_ENABLED_I, CPU_FLASH_WR_I, FLASH_BYTE_DONE_I} = '0;
    {SFR_ADDR_I, SFR_WDATA_I, CFG1_WDATA_I, CPU_FLASH_PAGE_I} = '0;
    #2;
    do_reset();
    chk({EARLY_BOOT_O, CODE_LOCK_O, EMU_CLK_EN_O, CFG1_RDATA_O}, 11'h400, "reset state");
    emu.op(0, 7'h01, g, r);
    chk({g, r}, 2'b01, "early emu");
    sfr(1, csl_pkg::ADDR_FLASH_CTL, 8'h00);
    chk(rd & 8'hbc, 8'h80, "early flag");
    boot_end();
    chk(EMU_HALT_CPU_O, 1, "halt allowed");
    emu.op(0, 7'h01, g, r);
    chk({g, r}, 2'b10, "open read");
    for (int k = 1; k < 3; k++) begin
      emu.op(k, 7'h05, g, r);
      chk({g, r}, 2'b10, "open emu");
    end
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h40);
    chk(CODE_LOCK_O, m_lock, "late lock");
    repeat (6) begin
      d = 8'(rnd());
      if (d == csl_pkg::CODE_PAGE_ERASE || d == csl_pkg::CODE_MASS_ERASE) d = 8'h00;
      sfr(0, csl_pkg::ADDR_ERASE_TRIGGER, d);
      chk({pe, me}, 0, "other code");
    end
    p = 7'(rnd());
    sfr(0, csl_pkg::ADDR_PAGE_SEL, {p, 1'b0});
    sfr(0, csl_pkg::ADDR_ERASE_TRIGGER, csl_pkg::CODE_PAGE_ERASE);
    chk({pe, pa}, {1'b1, p}, "page erase");
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h02);
    sfr(0, csl_pkg::ADDR_ERASE_TRIGGER, csl_pkg::CODE_MASS_ERASE);
    chk({me, pc}, 2'b11, "mass erase");
    sfr(0, csl_pkg::ADDR_ERASE_TRIGGER, csl_pkg::CODE_MASS_ERASE);
    chk({me, pc}, 2'b00, "unarmed mass");
    emu.enable(1'b0);
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h02);
    sfr(0, csl_pkg::ADDR_ERASE_TRIGGER, csl_pkg::CODE_MASS_ERASE);
    chk({me, pc}, 2'b00, "port off mass");
    emu.enable(1'b1);
    INT_ENABLED_I = 1'b1;
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h01);
    chk(CODE_WRITE_ENABLE_O, 0, "we blocked");
    INT_ENABLED_I = 1'b0;
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h01);
    chk(CODE_WRITE_ENABLE_O, 1, "we set");
    cpu_wr(7'h00);
    chk({fw, fp, CODE_WRITE_ENABLE_O}, 9'h100, "open write");
    $display("test 1 done");
    do_reset();
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h40);
    m_lock = 1;
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h00);
    chk(CODE_LOCK_O, m_lock, "lock set");
    boot_end();
    chk(EMU_HALT_CPU_O, 0, "halt locked");
    sfr(1, csl_pkg::ADDR_FLASH_CTL, 8'h00);
    chk(rd, 8'h40, "lock flag");
    for (int k = 0; k < 3; k++) begin
      emu.op(k, 7'h03, g, r);
      chk({g, r}, 2'b01, "locked emu");
    end
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h02);
    emu.op(3, 7'h03, g, r);
    chk({g, r}, 2'b10, "locked bulk");
    for (int k = 0; k < 2; k++) begin
      sfr(0, csl_pkg::ADDR_PAGE_SEL, 8'(k * 2));
      sfr(0, csl_pkg::ADDR_ERASE_TRIGGER, csl_pkg::CODE_PAGE_ERASE);
      chk({pe, pa}, {k[0], 7'(k)}, "locked page erase");
    end
    for (int k = 0; k < 3; k += 2) begin
      sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h01);
      cpu_wr(7'(k));
      chk({fw, fp}, {k != 0, 7'(k)}, "locked write");
    end
    {CFG1_WR_I, CFG1_WDATA_I} = {1'b1, 8'h20};
    @(posedge SYS_CLK_I);
    #2;
    CFG1_WR_I = 1'b0;
    repeat (2) @(posedge SYS_CLK_I);
    #2;
    chk({EMU_CLK_EN_O, CFG1_RDATA_O}, 9'h020, "clock off");
    sfr(0, csl_pkg::ADDR_FLASH_CTL, 8'h02);
    emu.op(3, 7'h03, g, r);
    chk({g, r}, 2'b01, "clock off bulk");
    // the programmer resets the chip after erase to regain access
    do_reset();
    chk({CODE_LOCK_O, CFG1_RDATA_O}, 9'h000, "lock after reset");
    $display("test 2 done");
    conclude();
  end
endmodule // code_security_lock_bench
`default_nettype wire
